//--- src/ccs_core_clock_switch.sv
// core clock source switch: oscillator, bit clock pin or pll
`timescale 1ns/1ps
module ccs_core_clock_switch (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // control bits from the register block
    input wire logic i_clock_present,
    input wire ccs_pkg::ccs_cfg_t i_cfg,
    // control port activity, same clock
    input wire logic i_i2c_busy,
    input wire logic i_i2c_stop,
    // bit clock activity detector from the pin
    input wire logic i_bit_clock_running,
    // status
    output ccs_pkg::ccs_status_t o_status,
    // clock gate enables
    output logic o_osc_gate_en,
    output logic o_ext_gate_en,
    output logic o_pin_gate_en,
    output logic o_pll_gate_en,
    output logic o_ctrl_clk_from_ext,
    output logic o_osc_enable,
    // audio path and rate
    output logic o_serial_port_enable,
    output logic o_master_clock_region_div,
    output logic o_internal_rate_select
);
    ccs_pkg::ccs_state_t state;
    ccs_pkg::ccs_state_t next_state;
    logic [11:0] count;
    logic [11:0] next_count;
    logic present_d;
    logic bclk_run;
    logic ext_req;
    logic next_ext_req;
    logic src_pll;
    logic next_src_pll;
    logic osc_a;
    logic osc_b;
    logic ext_settled;
    logic pin_a;
    logic pll_b;
    logic src_settled;
    ccs_pkg::ccs_status_t next_status;
    logic next_osc_enable;
    logic next_sp_en;
    logic next_div;
    logic next_rate;
    logic rise;
    logic fall;

    // pin-side activity crosses into the system clock
    ccs_sync2 u_bclk_sync (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_async(i_bit_clock_running),
        .o_sync(bclk_run)
    );

    // oscillator versus external master clock
    ccs_glitchless_sel u_core_sel (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_req(ext_req),
        .o_en_a(osc_a),
        .o_en_b(osc_b),
        .o_settled(ext_settled)
    );

    // pin directly versus pll output
    ccs_glitchless_sel u_src_sel (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_req(src_pll),
        .o_en_a(pin_a),
        .o_en_b(pll_b),
        .o_settled(src_settled)
    );

    assign rise = i_clock_present && !present_d;
    assign fall = !i_clock_present && present_d;

    // switch sequencer; the oscillator leaves power-down before switching back
    always_comb begin
        next_state = state;
        next_count = count;
        next_ext_req = ext_req;
        next_osc_enable = o_osc_enable;
        case (state)
            ccs_pkg::ST_OSC: begin
                if (rise && bclk_run) begin
                    next_state = ccs_pkg::ST_WAIT_UP;
                end
            end
            ccs_pkg::ST_WAIT_UP: begin
                if (!i_clock_present) begin
                    next_state = ccs_pkg::ST_OSC;
                end else if (i_i2c_stop && !i_i2c_busy) begin
                    next_state = ccs_pkg::ST_SWITCH_UP;
                    next_count = 12'h000;
                    next_ext_req = 1'b1;
                end
            end
            ccs_pkg::ST_SWITCH_UP: begin
                // full interval even if the mux settles early
                if (count == ccs_pkg::SWITCH_LAST && ext_settled) begin
                    next_state = ccs_pkg::ST_EXT;
                    next_osc_enable = 1'b0;
                end else if (count != ccs_pkg::SWITCH_LAST) begin
                    next_count = count + 12'h001;
                end
            end
            ccs_pkg::ST_EXT: begin
                if (fall) begin
                    next_state = ccs_pkg::ST_WAIT_DN;
                end
            end
            ccs_pkg::ST_WAIT_DN: begin
                if (i_i2c_stop && !i_i2c_busy) begin
                    next_state = ccs_pkg::ST_SWITCH_DN;
                    next_count = 12'h000;
                    next_ext_req = 1'b0;
                    next_osc_enable = 1'b1;
                end
            end
            ccs_pkg::ST_SWITCH_DN: begin
                if (count == ccs_pkg::SWITCH_LAST && ext_settled) begin
                    next_state = ccs_pkg::ST_OSC;
                end else if (count != ccs_pkg::SWITCH_LAST) begin
                    next_count = count + 12'h001;
                end
            end
            default: begin
                next_state = ccs_pkg::ST_OSC;
                next_ext_req = 1'b0;
                next_osc_enable = 1'b1;
            end
        endcase
    end

    // gray status, one bit per step in either direction
    always_comb begin
        next_status.oscillator_powered_status = next_osc_enable;
        case (next_state)
            ccs_pkg::ST_SWITCH_UP,
            ccs_pkg::ST_SWITCH_DN: begin
                next_status.clock_switch_state = ccs_pkg::STAT_TRANS;
            end
            ccs_pkg::ST_EXT,
            ccs_pkg::ST_WAIT_DN: begin
                next_status.clock_switch_state = ccs_pkg::STAT_EXT;
            end
            default: begin
                next_status.clock_switch_state = ccs_pkg::STAT_OSC;
            end
        endcase
    end

    // source, divider, rate and serial port enable
    always_comb begin
        next_src_pll = i_cfg.source_pll;
        next_div = i_cfg.region_div;
        // 11.2896 and 12.288 both use 1; only 12 MHz uses 0
        next_rate = (i_cfg.freq_code != ccs_pkg::FREQ_12M);
        // serial port never on the oscillator
        next_sp_en = (next_state == ccs_pkg::ST_EXT) && i_clock_present;
    end

    // state registers; reset always lands on the oscillator
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            state <= ccs_pkg::ST_OSC;
            count <= 12'h000;
            ext_req <= 1'b0;
            present_d <= 1'b0;
            o_osc_enable <= ccs_pkg::RST_OSC_POWERED;
            o_status <= {ccs_pkg::STAT_OSC, ccs_pkg::RST_OSC_POWERED};
            src_pll <= 1'b0;
            o_serial_port_enable <= 1'b0;
            o_master_clock_region_div <= 1'b0;
            o_internal_rate_select <= ccs_pkg::RST_RATE_SEL;
        end else begin
            state <= next_state;
            count <= next_count;
            ext_req <= next_ext_req;
            present_d <= i_clock_present;
            o_osc_enable <= next_osc_enable;
            o_status <= next_status;
            src_pll <= next_src_pll;
            o_serial_port_enable <= next_sp_en;
            o_master_clock_region_div <= next_div;
            o_internal_rate_select <= next_rate;
        end
    end

    // gate enables retimed so every output is a flop
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_osc_gate_en <= 1'b1;
            o_ext_gate_en <= 1'b0;
            o_pin_gate_en <= 1'b1;
            o_pll_gate_en <= 1'b0;
            o_ctrl_clk_from_ext <= 1'b0;
        end else begin
            o_osc_gate_en <= osc_a;
            o_ext_gate_en <= osc_b;
            o_pin_gate_en <= pin_a && src_settled;
            o_pll_gate_en <= pll_b;
            // control port shares the selected master clock
            o_ctrl_clk_from_ext <= osc_b;
        end
    end

    sequence s_up_start;
        state == ccs_pkg::ST_WAIT_UP && i_i2c_stop && !i_i2c_busy
            && i_clock_present;
    endsequence

    sequence s_in_trans_2;
        o_status.clock_switch_state == ccs_pkg::STAT_TRANS [*2];
    endsequence

    property p_reset_osc;
        @(posedge i_clk_sys) $fell(i_rst) |->
            state == ccs_pkg::ST_OSC && o_status.oscillator_powered_status;
    endproperty
    a_reset_osc: assert property (p_reset_osc)
        else $error("not on oscillator after reset");

    property p_gray;
        @(posedge i_clk_sys) disable iff (i_rst)
        $changed(o_status.clock_switch_state) |->
            $countones(o_status.clock_switch_state
                ^ $past(o_status.clock_switch_state)) == 1;
    endproperty
    a_gray: assert property (p_gray)
        else $error("status changed more than one bit");

    property p_osc_status;
        @(posedge i_clk_sys) disable iff (i_rst)
        o_status.oscillator_powered_status == o_osc_enable
            && (o_osc_enable
            || o_status.clock_switch_state == ccs_pkg::STAT_EXT);
    endproperty
    a_osc_status: assert property (p_osc_status)
        else $error("oscillator status disagrees with enable");

    property p_rise_waits;
        @(posedge i_clk_sys) disable iff (i_rst)
        state == ccs_pkg::ST_OSC && rise && bclk_run |=>
            state == ccs_pkg::ST_WAIT_UP
            && o_status.clock_switch_state == ccs_pkg::STAT_OSC;
    endproperty
    a_rise_waits: assert property (p_rise_waits)
        else $error("clock present rise did not arm switch");

    property p_up_start;
        @(posedge i_clk_sys) disable iff (i_rst)
        s_up_start |=> s_in_trans_2;
    endproperty
    a_up_start: assert property (p_up_start)
        else $error("switch did not start after stop");

    property p_busy_holds;
        @(posedge i_clk_sys) disable iff (i_rst)
        state == ccs_pkg::ST_WAIT_DN && i_i2c_busy |=>
            state == ccs_pkg::ST_WAIT_DN;
    endproperty
    a_busy_holds: assert property (p_busy_holds)
        else $error("switch began during a transaction");

    property p_trans_length;
        @(posedge i_clk_sys) disable iff (i_rst)
        state == ccs_pkg::ST_SWITCH_UP && count != ccs_pkg::SWITCH_LAST
            |=> o_status.clock_switch_state == ccs_pkg::STAT_TRANS;
    endproperty
    a_trans_length: assert property (p_trans_length)
        else $error("transition ended before interval");

    property p_fall_back;
        @(posedge i_clk_sys) disable iff (i_rst)
        state == ccs_pkg::ST_EXT && fall |=> state == ccs_pkg::ST_WAIT_DN;
    endproperty
    a_fall_back: assert property (p_fall_back)
        else $error("clock present fall ignored");

    property p_sp_ext;
        @(posedge i_clk_sys) disable iff (i_rst)
        o_serial_port_enable |-> o_ext_gate_en && !o_osc_gate_en;
    endproperty
    a_sp_ext: assert property (p_sp_ext)
        else $error("serial port enabled off the bit clock");

    property p_rate;
        @(posedge i_clk_sys) disable iff (i_rst)
        1'b1 |=> o_internal_rate_select
            == ($past(i_cfg.freq_code) != ccs_pkg::FREQ_12M);
    endproperty
    a_rate: assert property (p_rate)
        else $error("wrong internal rate select");

    property p_ctrl_clk;
        @(posedge i_clk_sys) disable iff (i_rst)
        o_ctrl_clk_from_ext == o_ext_gate_en;
    endproperty
    a_ctrl_clk: assert property (p_ctrl_clk)
        else $error("control clock not following master clock");
endmodule

//--- src/ccs_pkg.sv
// shared constants and types for the core clock source switch
package ccs_pkg;
    // system clock and switching interval
    localparam int CLK_HZ = 20_000_000;
    localparam int SWITCH_US = 150;
    localparam int SWITCH_CYCLES = (SWITCH_US * (CLK_HZ / 1_000_000));
    localparam logic [11:0] SWITCH_LAST = 12'(SWITCH_CYCLES - 1);
    // dead cycles between dropping one clock enable and raising the other
    localparam logic [1:0] MUX_GAP_LAST = 2'h2;
    // clock switch state codes, gray ordered osc <-> trans <-> ext
    localparam logic [1:0] STAT_OSC = 2'h0;
    localparam logic [1:0] STAT_TRANS = 2'h1;
    localparam logic [1:0] STAT_EXT = 2'h3;
    // master clock frequency codes
    localparam logic [1:0] FREQ_11M2896 = 2'h0;
    localparam logic [1:0] FREQ_12M = 2'h1;
    localparam logic [1:0] FREQ_12M288 = 2'h2;
    // reset values
    localparam logic RST_OSC_POWERED = 1'b1;
    localparam logic RST_RATE_SEL = 1'b1;

    typedef enum logic [5:0] {
        ST_OSC = 6'h01,
        ST_WAIT_UP = 6'h02,
        ST_SWITCH_UP = 6'h04,
        ST_EXT = 6'h08,
        ST_WAIT_DN = 6'h10,
        ST_SWITCH_DN = 6'h20
    } ccs_state_t;

    typedef struct packed {
        logic source_pll;
        logic region_div;
        logic [1:0] freq_code;
    } ccs_cfg_t;

    typedef struct packed {
        logic [1:0] clock_switch_state;
        logic oscillator_powered_status;
    } ccs_status_t;
endpackage

//--- src/ccs_sync2.sv
// two-flop level synchroniser for pin inputs
`timescale 1ns/1ps
module ccs_sync2 (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // level in and out
    input wire logic i_async,
    output logic o_sync
);
    logic meta;

    // first flop feeds only the second
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            meta <= 1'b0;
            o_sync <= 1'b0;
        end else begin
            meta <= i_async;
            o_sync <= meta;
        end
    end
endmodule

//--- src/ccs_glitchless_sel.sv
// break-before-make enable pair for a glitchless two-input clock mux
`timescale 1ns/1ps
module ccs_glitchless_sel (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // request: 0 selects input a, 1 selects input b
    input wire logic i_req,
    // gate enables, one-hot or both low during the gap
    output logic o_en_a,
    output logic o_en_b,
    output logic o_settled
);
    logic owner;
    logic [1:0] gap;
    logic next_en_a;
    logic next_en_b;
    logic next_owner;
    logic [1:0] next_gap;
    logic next_settled;

    // never both enables high: the old clock is gated before the new one
    always_comb begin
        next_en_a = o_en_a;
        next_en_b = o_en_b;
        next_owner = owner;
        next_gap = gap;
        next_settled = o_settled;
        if (i_req != owner) begin
            next_en_a = 1'b0;
            next_en_b = 1'b0;
            next_owner = i_req;
            next_gap = 2'h0;
            next_settled = 1'b0;
        end else if (!o_settled) begin
            if (gap == ccs_pkg::MUX_GAP_LAST) begin
                next_en_a = !owner;
                next_en_b = owner;
                next_settled = 1'b1;
            end else begin
                next_gap = gap + 2'h1;
            end
        end
    end

    // reset always lands on input a
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_en_a <= 1'b1;
            o_en_b <= 1'b0;
            owner <= 1'b0;
            gap <= 2'h0;
            o_settled <= 1'b1;
        end else begin
            o_en_a <= next_en_a;
            o_en_b <= next_en_b;
            owner <= next_owner;
            gap <= next_gap;
            o_settled <= next_settled;
        end
    end

    property p_never_both;
        @(posedge i_clk_sys) disable iff (i_rst)
        !(o_en_a && o_en_b);
    endproperty
    a_never_both: assert property (p_never_both)
        else $error("both clock enables high");
endmodule

//--- testbench/ccs_host_model.sv
// host controller model: control port traffic and bit clock supply
`timescale 1ns/1ps
module ccs_host_model (
    // clock
    input wire logic i_clk_sys,
    // switch state as the host reads it back
    input wire ccs_pkg::ccs_status_t i_status,
    // control port activity and clock supply toward the block
    output logic o_busy,
    output logic o_stop,
    output logic o_bclk_run,
    output logic o_present,
    output ccs_pkg::ccs_cfg_t o_cfg
);
    int quiet = ccs_pkg::SWITCH_CYCLES;

    // idle bus, no bit clock, oscillator clocking at time zero
    initial begin
        o_busy = 1'b0;
        o_stop = 1'b0;
        o_bclk_run = 1'b0;
        o_present = 1'b0;
        o_cfg = '0;
    end

    // cycles since the last stop condition
    always @(posedge i_clk_sys) begin
        if (o_stop)
            quiet <= 0;
        else if (quiet < ccs_pkg::SWITCH_CYCLES)
            quiet <= quiet + 1;
    end

    // one control access bad raises stop while still busy
    task automatic xact(input int len, input logic bad);
        // stay off the bus until the post-stop gap has run out
        while (quiet < ccs_pkg::SWITCH_CYCLES)
            @(negedge i_clk_sys);
        @(negedge i_clk_sys);
        o_busy = 1'b1;
        repeat (len) @(negedge i_clk_sys);
        o_busy = bad;
        o_stop = 1'b1;
        @(negedge i_clk_sys);
        o_busy = 1'b0;
        o_stop = 1'b0;
    endtask

    // clock-present bit, set at the next falling edge whether or not the bit clock is running
    task automatic set_present(input logic v);
        @(negedge i_clk_sys);
        o_present = v;
    endtask

    // configuration word driven as given; region divider and clock code are not checked
    task automatic set_cfg(input ccs_pkg::ccs_cfg_t c);
        @(negedge i_clk_sys);
        o_cfg = c;
    endtask

    // bit clock stops once the core is back on the oscillator, or after 10000 cycles
    task automatic set_bclk(input logic v, output bit ok);
        ok = 1'b0;
        for (int i = 0; i < 10000; i++) begin
            if (v || i_status.clock_switch_state === ccs_pkg::STAT_OSC) begin
                ok = 1'b1;
                break;
            end
            @(negedge i_clk_sys);
        end
        @(negedge i_clk_sys);
        o_bclk_run = v;
    endtask
endmodule

//--- testbench/tb.sv
// self-checking bench for the core clock source switch
`timescale 1ns/1ps
`define CHK(got, exp) \
    begin \
        n_checks++; \
        if ((got) !== (exp)) begin \
            fails++; \
            $display("Error at %0t: got %h expected %h", $time, got, exp); \
        end \
    end
module tb;
    logic i_clk_sys = 1'b0;
    logic i_rst = 1'b1;
    logic busy, stop, bclk, present;
    ccs_pkg::ccs_cfg_t cfg;
    logic h_busy, h_stop, h_bclk, h_present;
    ccs_pkg::ccs_cfg_t h_cfg;
    ccs_pkg::ccs_status_t status;
    logic osc_gate, ext_gate, pin_gate, pll_gate, ctrl_ext;
    logic osc_en, sp_en, div, rate;
    logic [1:0] prev_st = 2'h0;
    int fails = 0;
    int n_checks = 0;

    // 20 MHz system clock
    always #25 i_clk_sys = ~i_clk_sys;

    ccs_core_clock_switch dut (
        .i_clk_sys(i_clk_sys), .i_rst(i_rst),
        .i_clock_present(present), .i_cfg(cfg),
        .i_i2c_busy(busy), .i_i2c_stop(stop),
        .i_bit_clock_running(bclk), .o_status(status),
        .o_osc_gate_en(osc_gate), .o_ext_gate_en(ext_gate),
        .o_pin_gate_en(pin_gate), .o_pll_gate_en(pll_gate),
        .o_ctrl_clk_from_ext(ctrl_ext), .o_osc_enable(osc_en),
        .o_serial_port_enable(sp_en),
        .o_master_clock_region_div(div),
        .o_internal_rate_select(rate)
    );

    ccs_host_model host (
        .i_clk_sys(i_clk_sys), .i_status(status), .o_busy(h_busy),
        .o_stop(h_stop), .o_bclk_run(h_bclk), .o_present(h_present),
        .o_cfg(h_cfg)
    );

    // host drive points, one place to tap or hold back stimulus
    assign busy = h_busy;
    assign stop = h_stop;
    assign bclk = h_bclk;
    assign present = h_present;
    assign cfg = h_cfg;

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge i_clk_sys);
    endtask

    // length of the in-transition report, bounded wait
    task automatic count_trans(output int n);
        bit seen;
        n = 0;
        seen = 1'b0;
        for (int i = 0; i < 4000; i++) begin
            if (status.clock_switch_state === ccs_pkg::STAT_TRANS) begin
                if (!seen) `CHK(status, {ccs_pkg::STAT_TRANS, 1'b1});
                seen = 1'b1;
                n++;
            end else if (seen)
                break;
            @(negedge i_clk_sys);
        end
        if (n == 0) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, n, 1);
            close_out();
        end
    endtask

    // gates never overlap, state code moves one bit at a time
    always @(negedge i_clk_sys) begin
        if (!i_rst) begin
            `CHK({osc_gate & ext_gate, pin_gate & pll_gate}, 2'h0);
            `CHK($countones(status.clock_switch_state ^ prev_st) < 2, 1'b1);
        end
        prev_st = status.clock_switch_state;
    end

    // hang guard
    initial begin
        repeat (100000) @(posedge i_clk_sys);
        fails++;
        $display("Error at %0t: got %h expected %h", $time, 1, 0);
        close_out();
    end

    initial begin
        int n;
        bit ok;
        cyc(12);
        `CHK(status, 3'h1);
        `CHK({osc_gate, ext_gate, osc_en, sp_en}, 4'ha);
        `CHK({pin_gate, pll_gate, ctrl_ext, div, rate}, 5'h11);
        i_rst = 1'b0;
        $display("test reset done");
        // rise without bit clock must be ignored
        host.set_present(1'b1);
        host.xact(1, 1'b0);
        cyc(20);
        `CHK(status, 3'h1);
        host.set_present(1'b0);
        $display("test refused rise done");
        // armed switch waits out a stop that came while busy
        host.set_bclk(1'b1, ok);
        cyc(4);
        host.set_present(1'b1);
        host.xact(3, 1'b1);
        cyc(20);
        `CHK(status, 3'h1);
        host.xact(3, 1'b0);
        count_trans(n);
        `CHK(n, ccs_pkg::SWITCH_CYCLES);
        cyc(2);
        `CHK(status, {ccs_pkg::STAT_EXT, 1'b0});
        `CHK({osc_gate, ext_gate, ctrl_ext, osc_en, sp_en}, 5'h0d);
        $display("test switch up done");
        // divider and rate select for every clock code
        for (int k = 0; k < 6; k++) begin
            host.set_cfg({1'b0, k[0], k[2:1]});
            cyc(2);
            `CHK({div, rate}, {k[0], k[2:1] != 2'h1});
        end
        host.set_cfg(4'h9);
        cyc(8);
        `CHK({pin_gate, pll_gate}, 2'h1);
        host.set_cfg(4'h1);
        cyc(8);
        `CHK({pin_gate, pll_gate}, 2'h2);
        $display("test config done");
        // back to the oscillator, held until the stop
        host.set_present(1'b0);
        cyc(2);
        `CHK(sp_en, 1'b0);
        cyc(20);
        `CHK(status, {ccs_pkg::STAT_EXT, 1'b0});
        host.xact(2, 1'b0);
        count_trans(n);
        `CHK(n, ccs_pkg::SWITCH_CYCLES);
        cyc(2);
        `CHK(status, 3'h1);
        `CHK({osc_gate, ext_gate, ctrl_ext, osc_en}, 4'h9);
        host.set_bclk(1'b0, ok);
        `CHK(ok, 1'b1);
        if (!ok)
            close_out();
        $display("test switch down done");
        // reset in mid transition
        host.set_bclk(1'b1, ok);
        cyc(4);
        // clearing present while armed cancels; a later stop does nothing
        host.set_present(1'b1);
        host.set_present(1'b0);
        host.xact(1, 1'b0);
        cyc(20);
        `CHK(status, 3'h1);
        host.set_present(1'b1);
        host.xact(1, 1'b0);
        cyc(100);
        `CHK(status.clock_switch_state, ccs_pkg::STAT_TRANS);
        i_rst = 1'b1;
        cyc(2);
        `CHK(status, 3'h1);
        `CHK({osc_gate, ext_gate, osc_en, sp_en}, 4'ha);
        i_rst = 1'b0;
        cyc(8);
        `CHK(status, 3'h1);
        $display("test reset mid switch done");
        close_out();
    end
endmodule
